// ---- verilog/crsb_regs_defines.vh ----
`ifndef CRSB_REGS_DEFINES_VH
`define CRSB_REGS_DEFINES_VH

// register indices on the wishbone slave (byte address = index * 4)
`define CRSB_IDX_DATA0 5'h00
`define CRSB_IDX_DATA1 5'h01
`define CRSB_IDX_DATA2 5'h02
`define CRSB_IDX_DATA3 5'h03
`define CRSB_IDX_ADDR0 5'h04
`define CRSB_IDX_ADDR1 5'h05
`define CRSB_IDX_FRAME 5'h06
`define CRSB_IDX_IPTR 5'h07
`define CRSB_IDX_VTAB 5'h08
`define CRSB_IDX_USP 5'h09
`define CRSB_IDX_ISP 5'h0A
`define CRSB_IDX_STATIC 5'h0B
`define CRSB_IDX_STATUS 5'h0C
`define CRSB_IDX_LONG0 5'h0D
`define CRSB_IDX_LONG1 5'h0E
`define CRSB_IDX_LONGA 5'h0F
`define CRSB_IDX_ACTSP 5'h10

// status word fields
`define CRSB_SW_CARRY 0
`define CRSB_SW_STEP 1
`define CRSB_SW_ZERO 2
`define CRSB_SW_SIGN 3
`define CRSB_SW_BANK 4
`define CRSB_SW_OVFL 5
`define CRSB_SW_IRQEN 6
`define CRSB_SW_STACK 7
`define CRSB_SW_IPL_LO 12
`define CRSB_SW_IPL_HI 14
`define CRSB_SW_USED_MASK 16'h70FF

// reset values
`define CRSB_RST_16 16'h0000
`define CRSB_RST_20 20'h00000
`define CRSB_RST_SW 16'h0000

// software interrupts below this number switch to the irq stack
`define CRSB_SWI_STACK_LIMIT 6'h20

`endif

// ---- verilog/crsb_register_set.v ----
// Behaviour
// - thirteen registers; data, address and frame base duplicated per bank.
// - data registers 16 bits; data zero and one split into byte halves.
// - data two above zero and three above one form 32-bit pairs.
// - two 16-bit address registers; addr one above zero forms long pair.
// - frame base pointer is 16 bits for frame-relative addressing.
// - instruction pointer is 20 bits, address of next instruction.
// - vector table base is 20 bits, interrupt table start address.
// - two 16-bit stack pointers, chosen by status bit 7.
// - static base pointer is 16 bits for static-relative addressing.
// - carry bit 0 captures carry, borrow or shift-out.
// - step bit 1 raises step interrupt per instruction; cleared on acknowledge.
// - zero bit 2 set on zero result, else cleared.
// - sign bit 3 set on negative result, else cleared.
// - bank bit 4 routes banked accesses to bank 0 or 1.
// - overflow bit 5 set on overflow, else cleared.
// - irq enable bit 6 gates maskable interrupts; cleared on acknowledge.
// - stack bit 7 clear selects irq stack; cleared by hw irq, swi 0-31.
// - priority bits 12-14; accept interrupt only if strictly above level.
// - status bits 8-11 and 15 reserved, no function.
// - after reset all registers read zero.
`timescale 1ns/100ps
`include "crsb_regs_defines.vh"

module crsb_register_set #(
    parameter DW = 16,
    parameter PW = 20
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // wishbone slave
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [6:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatIn,
    output reg [31:0] wbDatOut,
    output wire wbAck,
    // core read and write port
    input wire coreWe,
    input wire [4:0] coreIdx,
    input wire [1:0] coreByteEn,
    input wire [31:0] coreWData,
    output reg [31:0] coreRData,
    // instruction pointer
    input wire ipLoad,
    input wire [PW-1:0] ipNext,
    output wire [PW-1:0] instrPointer,
    // alu flags
    input wire aluFlagWe,
    input wire aluCarry,
    input wire aluZero,
    input wire aluSign,
    input wire aluOvfl,
    // interrupt and instruction events
    input wire instrDone,
    input wire irqRequest,
    input wire irqMaskable,
    input wire [2:0] irqPriority,
    input wire irqAck,
    input wire stepAck,
    input wire swiExec,
    input wire [5:0] swiNumber,
    output wire stepIrq,
    output wire irqAccept,
    // status view
    output wire [15:0] statusWord,
    output wire [DW-1:0] activeStackPtr,
    output wire [2:0] cpuPriorityLevel
);

    // banked registers: index = bank*7 + slot
    reg [DW-1:0] bankReg [0:13];
    reg [PW-1:0] ipReg;
    reg [PW-1:0] vtabReg;
    reg [DW-1:0] uspReg;
    reg [DW-1:0] ispReg;
    reg [DW-1:0] sbReg;
    reg [15:0] swReg;
    reg [15:0] swNext;
    reg ackReg;
    integer i;

    wire bankSel = swReg[`CRSB_SW_BANK];
    wire wbReq = wbCyc & wbStb & ~ackReg;
    wire wbWr = wbReq & wbWe;
    wire [4:0] wbIdx = wbAdr[6:2];

    // slot position of a banked register, or 7 when not banked
    function [2:0] bankSlot;
        input [4:0] idx;
        begin
            if (idx <= `CRSB_IDX_FRAME) begin
                bankSlot = idx[2:0];
            end else begin
                bankSlot = 3'h7;
            end
        end
    endfunction

    // read multiplexer shared by bus and core
    function [31:0] readMux;
        input [4:0] idx;
        input bk;
        input [DW*14-1:0] flat;
        input [PW-1:0] ip;
        input [PW-1:0] vt;
        input [DW-1:0] us;
        input [DW-1:0] is;
        input [DW-1:0] sb;
        input [15:0] sw;
        reg [3:0] base;
        begin
            base = bk ? 4'h7 : 4'h0;
            readMux = 32'h00000000;
            case (idx)
                `CRSB_IDX_DATA0, `CRSB_IDX_DATA1, `CRSB_IDX_DATA2, `CRSB_IDX_DATA3,
                `CRSB_IDX_ADDR0, `CRSB_IDX_ADDR1, `CRSB_IDX_FRAME: begin
                    readMux = {16'h0000, flat[(base + {1'b0, idx[2:0]})*DW +: DW]};
                end
                `CRSB_IDX_IPTR: readMux = {12'h000, ip};
                `CRSB_IDX_VTAB: readMux = {12'h000, vt};
                `CRSB_IDX_USP: readMux = {16'h0000, us};
                `CRSB_IDX_ISP: readMux = {16'h0000, is};
                `CRSB_IDX_STATIC: readMux = {16'h0000, sb};
                // reserved status bits read zero
                `CRSB_IDX_STATUS: readMux = {16'h0000, sw & `CRSB_SW_USED_MASK};
                // long pairs: high word in upper half
                `CRSB_IDX_LONG0: readMux = {flat[(base + 4'h2)*DW +: DW],
                    flat[(base + 4'h0)*DW +: DW]};
                `CRSB_IDX_LONG1: readMux = {flat[(base + 4'h3)*DW +: DW],
                    flat[(base + 4'h1)*DW +: DW]};
                `CRSB_IDX_LONGA: readMux = {flat[(base + 4'h5)*DW +: DW],
                    flat[(base + 4'h4)*DW +: DW]};
                `CRSB_IDX_ACTSP: readMux = {16'h0000, sw[`CRSB_SW_STACK] ? us : is};
                default: readMux = 32'h00000000;
            endcase
        end
    endfunction

    wire [DW*14-1:0] bankFlat;
    genvar g;
    generate
        for (g = 0; g < 14; g = g + 1) begin : gFlat
            assign bankFlat[g*DW +: DW] = bankReg[g];
        end
    endgenerate

    // one write source per cycle: bus wins over core
    wire anyWe = wbWr | coreWe;
    wire [4:0] wIdx = wbWr ? wbIdx : coreIdx;
    wire [31:0] wData = wbWr ? wbDatIn : coreWData;
    wire [1:0] wByte = wbWr ? wbSel[1:0] : coreByteEn;
    wire [1:0] wHiByte = wbWr ? wbSel[3:2] : coreByteEn;

    // merge byte lanes into a 16-bit word
    function [15:0] byteMerge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] en;
        begin
            byteMerge = {en[1] ? nw[15:8] : old[15:8], en[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    wire [3:0] bankBase = bankSel ? 4'h7 : 4'h0;

    assign stepIrq = swReg[`CRSB_SW_STEP] & instrDone;
    // accept if non-maskable or enabled, and strictly above level
    assign irqAccept = irqRequest & (~irqMaskable | swReg[`CRSB_SW_IRQEN])
        & (irqPriority > swReg[`CRSB_SW_IPL_HI:`CRSB_SW_IPL_LO]);

    always @* begin
        swNext = swReg;
        if (anyWe && wIdx == `CRSB_IDX_STATUS) begin
            swNext = byteMerge(swReg, wData[15:0], wByte) & `CRSB_SW_USED_MASK;
        end
        if (aluFlagWe) begin
            swNext[`CRSB_SW_CARRY] = aluCarry;
            swNext[`CRSB_SW_ZERO] = aluZero;
            swNext[`CRSB_SW_SIGN] = aluSign;
            swNext[`CRSB_SW_OVFL] = aluOvfl;
        end
        if (stepAck) begin
            swNext[`CRSB_SW_STEP] = 1'b0;
        end
        if (irqAck) begin
            swNext[`CRSB_SW_IRQEN] = 1'b0;
            swNext[`CRSB_SW_STACK] = 1'b0;
        end
        if (swiExec && swiNumber < `CRSB_SWI_STACK_LIMIT) begin
            swNext[`CRSB_SW_STACK] = 1'b0;
        end
        swNext = swNext & `CRSB_SW_USED_MASK;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < 14; i = i + 1) begin
                bankReg[i] <= `CRSB_RST_16;
            end
            ipReg <= `CRSB_RST_20;
            vtabReg <= `CRSB_RST_20;
            uspReg <= `CRSB_RST_16;
            ispReg <= `CRSB_RST_16;
            sbReg <= `CRSB_RST_16;
            swReg <= `CRSB_RST_SW;
        end else begin
            swReg <= swNext;
            if (ipLoad) begin
                ipReg <= ipNext;
            end else if (anyWe && wIdx == `CRSB_IDX_IPTR) begin
                ipReg <= wData[PW-1:0];
            end
            if (anyWe) begin
                // banked write to current bank only
                if (bankSlot(wIdx) != 3'h7) begin
                    bankReg[bankBase + {1'b0, bankSlot(wIdx)}] <=
                        byteMerge(bankReg[bankBase + {1'b0, bankSlot(wIdx)}], wData[15:0], wByte);
                end
                case (wIdx)
                    `CRSB_IDX_VTAB: vtabReg <= wData[PW-1:0];
                    `CRSB_IDX_USP: uspReg <= byteMerge(uspReg, wData[15:0], wByte);
                    `CRSB_IDX_ISP: ispReg <= byteMerge(ispReg, wData[15:0], wByte);
                    `CRSB_IDX_ACTSP: begin
                        if (swReg[`CRSB_SW_STACK]) begin
                            uspReg <= byteMerge(uspReg, wData[15:0], wByte);
                        end else begin
                            ispReg <= byteMerge(ispReg, wData[15:0], wByte);
                        end
                    end
                    `CRSB_IDX_STATIC: sbReg <= byteMerge(sbReg, wData[15:0], wByte);
                    `CRSB_IDX_LONG0: begin
                        bankReg[bankBase] <= byteMerge(bankReg[bankBase], wData[15:0], wByte);
                        bankReg[bankBase + 4'h2] <=
                            byteMerge(bankReg[bankBase + 4'h2], wData[31:16], wHiByte);
                    end
                    `CRSB_IDX_LONG1: begin
                        bankReg[bankBase + 4'h1] <=
                            byteMerge(bankReg[bankBase + 4'h1], wData[15:0], wByte);
                        bankReg[bankBase + 4'h3] <=
                            byteMerge(bankReg[bankBase + 4'h3], wData[31:16], wHiByte);
                    end
                    `CRSB_IDX_LONGA: begin
                        bankReg[bankBase + 4'h4] <=
                            byteMerge(bankReg[bankBase + 4'h4], wData[15:0], wByte);
                        bankReg[bankBase + 4'h5] <=
                            byteMerge(bankReg[bankBase + 4'h5], wData[31:16], wHiByte);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // single-wait ack; reads registered for a clean data output
    always @(posedge clk) begin
        if (!rst_n) begin
            ackReg <= 1'b0;
            wbDatOut <= 32'h00000000;
        end else begin
            ackReg <= wbReq;
            if (wbReq && !wbWe) begin
                wbDatOut <= readMux(wbIdx, bankSel, bankFlat, ipReg, vtabReg, uspReg,
                    ispReg, sbReg, swReg);
            end
        end
    end
    assign wbAck = ackReg;

    // core read is combinational, current bank
    always @* begin
        coreRData = readMux(coreIdx, bankSel, bankFlat, ipReg, vtabReg, uspReg,
            ispReg, sbReg, swReg);
    end

    assign instrPointer = ipReg;
    assign statusWord = swReg;
    assign activeStackPtr = swReg[`CRSB_SW_STACK] ? uspReg : ispReg;
    assign cpuPriorityLevel = swReg[`CRSB_SW_IPL_HI:`CRSB_SW_IPL_LO];

endmodule // crsb_register_set

// ---- sim/crsb_register_set_asserts.sv ----
`timescale 1ns/100ps
module crsb_register_set_asserts #(
    parameter PW = 20
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // event inputs
    input wire instrDone,
    input wire irqRequest,
    input wire irqMaskable,
    input wire [2:0] irqPriority,
    input wire irqAck,
    input wire stepAck,
    input wire swiExec,
    input wire [5:0] swiNumber,
    // state outputs
    input wire [PW-1:0] instrPointer,
    input wire stepIrq,
    input wire irqAccept,
    input wire [15:0] statusWord,
    input wire [2:0] cpuPriorityLevel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_reset_clear: assert property ($rose(rst_n) |-> statusWord == 16'h0000 && instrPointer == 0)
        else $error("state not zero after reset");
    chk_reserved_zero: assert property ((statusWord & 16'h8F00) == 16'h0000)
        else $error("reserved status bits set");
    chk_ipl_view: assert property (cpuPriorityLevel == statusWord[14:12])
        else $error("priority view differs from status");
    // masked requests need the enable bit, all need a higher priority
    chk_accept_rule: assert property (irqAccept == (irqRequest &&
        (!irqMaskable || statusWord[6]) && irqPriority > statusWord[14:12]))
        else $error("interrupt accept wrong");
    chk_step_raise: assert property (stepIrq == (statusWord[1] && instrDone))
        else $error("step interrupt wrong");
    chk_step_clear: assert property (stepAck |=> !statusWord[1])
        else $error("step bit not cleared");
    chk_ack_clear: assert property (irqAck |=> !statusWord[6] && !statusWord[7])
        else $error("enable or stack bit kept after ack");
    chk_swi_stack: assert property (swiExec && swiNumber < 6'h20 |=> !statusWord[7])
        else $error("stack bit kept after low swi");
endmodule // crsb_register_set_asserts

bind crsb_register_set crsb_register_set_asserts #(.PW(PW)) u_chk (.clk(clk), .rst_n(rst_n),
    .instrDone(instrDone), .irqRequest(irqRequest), .irqMaskable(irqMaskable),
    .irqPriority(irqPriority), .irqAck(irqAck), .stepAck(stepAck), .swiExec(swiExec),
    .swiNumber(swiNumber), .instrPointer(instrPointer), .stepIrq(stepIrq),
    .irqAccept(irqAccept), .statusWord(statusWord), .cpuPriorityLevel(cpuPriorityLevel));

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    reg clk, rst_n, wbCyc, wbStb, wbWe, coreWe, ipLoad, aluFlagWe, aluCarry, aluZero, aluSign;
    reg aluOvfl, instrDone, irqRequest, irqMaskable, irqAck, stepAck, swiExec;
    reg [6:0] wbAdr;
    reg [3:0] wbSel;
    reg [31:0] wbDatIn, coreWData, rd, lfsr, r;
    reg [4:0] coreIdx;
    reg [1:0] coreByteEn;
    reg [19:0] ipNext;
    reg [2:0] irqPriority;
    reg [5:0] swiNumber;
    wire [31:0] wbDatOut, coreRData;
    wire wbAck, stepIrq, irqAccept;
    wire [19:0] instrPointer;
    wire [15:0] statusWord, activeStackPtr;
    wire [2:0] cpuPriorityLevel;
    integer errors, num_checks, i, j, k, n;
    // behavioural model: two banks of seven, plus the plain registers
    reg [15:0] bank [0:13];
    reg [19:0] m [7:11];
    reg [15:0] mSw;

    crsb_register_set uut (.clk(clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
        .coreWe(coreWe), .coreIdx(coreIdx), .coreByteEn(coreByteEn), .coreWData(coreWData),
        .coreRData(coreRData), .ipLoad(ipLoad), .ipNext(ipNext), .instrPointer(instrPointer),
        .aluFlagWe(aluFlagWe), .aluCarry(aluCarry), .aluZero(aluZero), .aluSign(aluSign),
        .aluOvfl(aluOvfl), .instrDone(instrDone), .irqRequest(irqRequest),
        .irqMaskable(irqMaskable), .irqPriority(irqPriority), .irqAck(irqAck),
        .stepAck(stepAck), .swiExec(swiExec), .swiNumber(swiNumber), .stepIrq(stepIrq),
        .irqAccept(irqAccept), .statusWord(statusWord), .activeStackPtr(activeStackPtr),
        .cpuPriorityLevel(cpuPriorityLevel));

    function [31:0] nx(input [31:0] v);
        nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function [15:0] bk(input [4:0] x);
        bk = bank[mSw[4] * 7 + x];
    endfunction
    function [31:0] expv(input [4:0] x);
        if (x < 7) expv = {16'h0000, bk(x)};
        else if (x < 12) expv = {12'h000, m[x]};
        else if (x == 12) expv = {16'h0000, mSw};
        else if (x == 13) expv = {bk(2), bk(0)};
        else if (x == 14) expv = {bk(3), bk(1)};
        else if (x == 15) expv = {bk(5), bk(4)};
        else if (x == 16) expv = {16'h0000, mSw[7] ? m[9][15:0] : m[10][15:0]};
        else expv = 32'h00000000;
    endfunction
    task mwr(input [4:0] x, input [31:0] d, input [1:0] s);
        if (x < 7 && s[0]) bank[mSw[4] * 7 + x][7:0] = d[7:0];
        if (x < 7 && s[1]) bank[mSw[4] * 7 + x][15:8] = d[15:8];
        if (x == 7 || x == 8) m[x] = d[19:0];
        if (x > 8 && x < 12) m[x] = {4'h0, d[15:0]};
        if (x == 12) mSw = d[15:0] & 16'h70FF;
    endtask
    task cmp(input [31:0] g, input [31:0] e);
        num_checks = num_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // one classic cycle; writes land in the model at the ack edge
    task xfer(input w, input [4:0] x, input [31:0] d, input [3:0] s);
        @(posedge clk);
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= w; wbAdr <= {x, 2'b00}; wbSel <= s; wbDatIn <= d;
        n = 0;
        // look at ack between edges, where the flop has settled
        do begin @(negedge clk); n = n + 1; end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) begin errors = errors + 1; stop_test; end
        rd = wbDatOut;
        if (w) mwr(x, d, s[1:0]);
        // release only after the edge that samples ack high
        @(posedge clk);
        wbCyc <= 1'b0; wbStb <= 1'b0;
    endtask
    task rdchk(input [4:0] x);
        xfer(1'b0, x, 32'h00000000, 4'hF);
        cmp(rd, expv(x));
        cmp({16'h0000, activeStackPtr}, expv(16));
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        errors = errors + 1;
        stop_test;
    end
    initial begin
        {rst_n, wbCyc, wbStb, wbWe, coreWe, ipLoad, aluFlagWe, aluCarry, aluZero} = 9'h000;
        {aluSign, aluOvfl, instrDone, irqRequest, irqMaskable, irqAck, stepAck, swiExec} = 8'h00;
        {wbAdr, wbSel, wbDatIn, coreWData, coreIdx, coreByteEn, ipNext} = 102'h0;
        {irqPriority, swiNumber} = 9'h000;
        errors = 0; num_checks = 0; lfsr = 81558; mSw = 16'h0000;
        for (i = 0; i < 14; i = i + 1) bank[i] = 16'h0000;
        for (i = 7; i < 12; i = i + 1) m[i] = 20'h00000;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped index included
        for (i = 0; i < 18; i = i + 1) rdchk(i);
        // random fills, status flips the bank mid-pass
        for (k = 0; k < 4; k = k + 1) begin
            for (i = 0; i < 13; i = i + 1) begin lfsr = nx(lfsr); xfer(1'b1, i, lfsr, 4'hF); end
            xfer(1'b1, 0, nx(lfsr), 4'h1);
            xfer(1'b1, 1, nx(nx(lfsr)), 4'h2);
            for (i = 0; i < 18; i = i + 1) rdchk(i);
            xfer(1'b1, 12, {27'h0, k[0], 4'h0}, 4'hF);
            for (i = 0; i < 7; i = i + 1) rdchk(i);
        end
        // instruction load and core write
        @(posedge clk); lfsr = nx(lfsr); ipLoad <= 1'b1; ipNext <= lfsr[19:0];
        @(posedge clk); ipLoad <= 1'b0; m[7] = ipNext;
        @(posedge clk); cmp({12'h000, instrPointer}, {12'h000, m[7]});
        coreWe <= 1'b1; coreIdx <= 5'h03; coreByteEn <= 2'h3; coreWData <= nx(lfsr);
        @(posedge clk); coreWe <= 1'b0; mwr(3, coreWData, 2'h3);
        @(posedge clk); cmp(coreRData, expv(coreIdx));
        rdchk(14);
        // random flag and interrupt events against the model
        for (k = 0; k < 4; k = k + 1) begin
            lfsr = nx(lfsr); xfer(1'b1, 12, lfsr, 4'hF);
            for (j = 0; j < 30; j = j + 1) begin
                @(negedge clk); cmp({16'h0000, statusWord}, {16'h0000, mSw});
                cmp({31'h0, stepIrq}, {31'h0, mSw[1] & instrDone});
                cmp({31'h0, irqAccept}, {31'h0, irqRequest & (~irqMaskable | mSw[6]) & (irqPriority > mSw[14:12])});
                cmp({29'h0, cpuPriorityLevel}, {29'h0, mSw[14:12]});
                if (aluFlagWe) {mSw[5], mSw[3], mSw[2], mSw[0]} = {aluOvfl, aluSign, aluZero, aluCarry};
                if (irqAck) mSw[7:6] = 2'b00;
                if (stepAck) mSw[1] = 1'b0;
                if (swiExec && swiNumber < 6'h20) mSw[7] = 1'b0;
                lfsr = nx(lfsr); r = (j < 29) ? lfsr : 32'h00000000;
                @(posedge clk);
                aluFlagWe <= r[0]; irqAck <= r[1] & r[2]; stepAck <= r[3] & r[4]; swiExec <= r[5];
                swiNumber <= r[11:6]; {aluOvfl, aluSign, aluZero, aluCarry} <= r[15:12];
                irqRequest <= r[16]; irqMaskable <= r[17]; irqPriority <= r[20:18];
                instrDone <= r[21];
            end
        end
        stop_test;
    end
endmodule // testbench
